// ---- hw/edge_detector.sv ----
`timescale 1ns/10ps
`default_nettype none

module edge_detector #(
    parameter int N = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    edge_if.det e
);
    typedef struct packed {
        logic armed;
        logic [N-1:0] prev;
        logic [N-1:0] req;
    } edge_state_s;

    edge_state_s st_r;
    edge_state_s st_nxt;

    if (N < 1) begin : gBadWidth
        $error("edge_detector needs at least one pin");
    end

    // first sample after reset only arms; no edge is invented from reset value
    always_comb begin
        st_nxt = st_r;
        st_nxt.armed = 1'b1;
        st_nxt.prev = e.level;
        st_nxt.req = '0;
        if (st_r.armed) begin
            st_nxt.req = (e.level & ~st_r.prev & e.riseEn) |
                         (~e.level & st_r.prev & e.fallEn);
        end
        if (rst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_r <= st_nxt;
    end

    assign e.req = st_r.req;

endmodule

`default_nettype wire

// ---- hw/input_and_io_port_pair.sv ----
// Summary of operation
// - input port reads current pin levels
// - input pins always routed to peripherals
// - one bit pulls six upper input pins
// - nmi edge polarity from edge register a
// - six irq pins request on selected edge
// - eight-bit io port, per-bit direction
// - select bit picks port or alternate signal
// - reset makes all io pins inputs
// - output latch holds until next write
// - writes update every latch bit
// - input bits read pin level
// - bit operations rewrite whole byte
// - alternate mode pin drive ignores direction bit
// - alternate output, direction 1: pin level
// - alternate output, direction 0: internal signal where altOutEn set, 0 otherwise
// - alternate input reads pin if direction 1
// - pull-up when enable and direction input
// - pull-up also on alternate direction-1 pins
// - serial clock, serial out support open drain
// - pull option register: bit 7 zero, reset 0
// - pull enable 1 means pull-ups used
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "gpio_pair_params.svh"
`timescale 1ns/10ps
`default_nettype none

module input_and_io_port_pair (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire gpio_pair_pkg::byte_t inPin,
    output gpio_pair_pkg::byte_t inPullUp,
    output gpio_pair_pkg::byte_t inRoute,
    output logic nmiReq,
    output logic [5:0] extIrqReq,
    input wire gpio_pair_pkg::byte_t ioPinIn,
    output gpio_pair_pkg::byte_t ioPinOut,
    output gpio_pair_pkg::byte_t ioPinOeN,
    output gpio_pair_pkg::byte_t ioPullUp,
    input wire gpio_pair_pkg::byte_t altOut,
    input wire gpio_pair_pkg::byte_t altOutEn,
    output gpio_pair_pkg::byte_t altIn
);
    import gpio_pair_pkg::*;

    port_state_s st_r;
    port_state_s st_nxt;

    edge_if #(.N(`EDGE_PINS)) ed();

    edge_detector #(.N(`EDGE_PINS)) edgeUnit (
        .core_clk(core_clk),
        .rst(rst),
        .e(ed.det)
    );

    // pin 0 is nmi, pins 1..6 are the six external irq pins
    assign ed.level = st_r.inS2[`EDGE_PINS-1:0];
    assign ed.riseEn = {st_r.edgeA[7:2], st_r.edgeA[`NMI_EDGE_BIT]};
    assign ed.fallEn = {st_r.edgeB[5:0], ~st_r.edgeA[`NMI_EDGE_BIT]};

    function automatic byte_t ioRead(port_state_s s, byte_t ao, byte_t aoe);
        byte_t r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            if (s.fsel[i]) begin
                if (s.dir[i]) begin
                    r[i] = s.ioS2[i];
                end else if (aoe[i]) begin
                    r[i] = ao[i];
                end else begin
                    r[i] = 1'b0;
                end
            end else if (s.dir[i]) begin
                r[i] = s.ioS2[i];
            end else begin
                r[i] = s.latch[i];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [`IDX_W-1:0] idx;
        logic drv;
        logic val;
        logic odOn;
        st_nxt = st_r;
        idx = '0;
        drv = 1'b0;
        val = 1'b0;
        odOn = 1'b0;

        // two-stage synchronisers on every pin
        st_nxt.inS1 = inPin;
        st_nxt.inS2 = st_r.inS1;
        st_nxt.ioS1 = ioPinIn;
        st_nxt.ioS2 = st_r.ioS1;

        // write channel: address and data taken in either order
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (awvalid && st_r.awready) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.waddr = awaddr;
        end
        if (wvalid && st_r.wready) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wdata = wdata[7:0];
            st_nxt.wLow = wstrb[0];
        end
        if (st_nxt.awHeld && st_nxt.wHeld && !st_nxt.bvalid) begin
            idx = st_nxt.waddr[`ADDR_W-1:2];
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `RESP_OK;
            case (idx)
                `IDX_INPORT: begin
                    // no direction register; writes are dropped
                    st_nxt.bresp = `RESP_OK;
                end
                `IDX_IODATA: begin
                    // whole byte lands in the latch, whatever the direction
                    if (st_nxt.wLow) begin
                        st_nxt.latch = st_nxt.wdata;
                    end
                end
                `IDX_IODIR: begin
                    if (st_nxt.wLow) begin
                        st_nxt.dir = st_nxt.wdata;
                    end
                end
                `IDX_IOFSEL: begin
                    if (st_nxt.wLow) begin
                        st_nxt.fsel = st_nxt.wdata;
                    end
                end
                `IDX_EDGE_A: begin
                    if (st_nxt.wLow) begin
                        st_nxt.edgeA = st_nxt.wdata;
                    end
                end
                `IDX_EDGE_B: begin
                    if (st_nxt.wLow) begin
                        st_nxt.edgeB = st_nxt.wdata;
                    end
                end
                `IDX_IOOD: begin
                    if (st_nxt.wLow) begin
                        st_nxt.od = st_nxt.wdata[1:0];
                    end
                end
                `IDX_PULL: begin
                    if (st_nxt.wLow) begin
                        st_nxt.pullOpt = st_nxt.wdata & `PULL_RW_MASK;
                    end
                end
                default: begin
                    st_nxt.bresp = `RESP_SLVERR;
                end
            endcase
        end
        st_nxt.awready = ~st_nxt.awHeld & ~st_nxt.bvalid;
        st_nxt.wready = ~st_nxt.wHeld & ~st_nxt.bvalid;

        // read channel: answer one cycle after the address is taken
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `RESP_OK;
            st_nxt.rdata = '0;
            case (araddr[`ADDR_W-1:2])
                `IDX_INPORT: st_nxt.rdata = st_r.inS2;
                `IDX_IODATA: st_nxt.rdata = ioRead(st_r, altOut, altOutEn);
                `IDX_IODIR: st_nxt.rdata = st_r.dir;
                `IDX_IOFSEL: st_nxt.rdata = st_r.fsel;
                `IDX_EDGE_A: st_nxt.rdata = st_r.edgeA;
                `IDX_EDGE_B: st_nxt.rdata = st_r.edgeB;
                `IDX_IOOD: st_nxt.rdata = {6'h0, st_r.od};
                `IDX_PULL: st_nxt.rdata = st_r.pullOpt;
                default: st_nxt.rresp = `RESP_SLVERR;
            endcase
        end
        st_nxt.arready = ~st_nxt.rvalid;

        // pin drivers: one cycle behind the registers
        for (int i = 0; i < 8; i++) begin
            if (st_r.fsel[i]) begin
                drv = altOutEn[i];
                val = altOut[i];
            end else begin
                drv = ~st_r.dir[i];
                val = st_r.latch[i];
            end
            odOn = (i == `OD_PIN_CLK && st_r.od[0]) ||
                   (i == `OD_PIN_OUT && st_r.od[1]);
            if (odOn && val) begin
                drv = 1'b0;
            end
            st_nxt.ioOut[i] = val;
            st_nxt.ioOeN[i] = ~drv;
        end

        // pull-ups; pins 1..0 of the input port have none
        st_nxt.inPull = {{6{st_r.pullOpt[`PULL_IN_BIT]}}, 2'h0};
        // alternate pins with direction 1 are pulled too; clear dir to avoid
        st_nxt.ioPull = st_r.dir & {8{st_r.pullOpt[`PULL_IO_BIT]}};

        if (rst) begin
            st_nxt = '0;
            // latch content is a don't-care after reset; zero keeps sims tidy
            st_nxt.dir = `DIR_RST;
            st_nxt.ioOeN = `OEN_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        st_r <= st_nxt;
    end

    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rresp = st_r.rresp;
    assign rdata = {24'h0, st_r.rdata};
    assign inRoute = st_r.inS2;
    assign altIn = st_r.ioS2;
    assign inPullUp = st_r.inPull;
    assign ioPullUp = st_r.ioPull;
    assign ioPinOut = st_r.ioOut;
    assign ioPinOeN = st_r.ioOeN;
    assign nmiReq = ed.req[0];
    assign extIrqReq = ed.req[`EDGE_PINS-1:1];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    inport_read_a: assert property (
        arvalid && arready && araddr[`ADDR_W-1:2] == `IDX_INPORT
        |=> rvalid && rdata[7:0] == $past(st_r.inS2))
        else $error("input port read does not show pin levels");

    in_pull_a: assert property (
        inPullUp[1:0] == 2'h0 &&
        inPullUp[7:2] == {6{$past(st_r.pullOpt[`PULL_IN_BIT])}})
        else $error("input port pull-ups wrong");

    nmi_edge_a: assert property (
        $rose(st_r.inS2[0]) && st_r.edgeA[`NMI_EDGE_BIT] && $past(st_r.edgeA[0])
        |=> nmiReq)
        else $error("nmi rising edge missed");

    irq_fall_a: assert property (
        $fell(st_r.inS2[1]) && st_r.edgeB[0] && $past(st_r.edgeB[0])
        |=> extIrqReq[0])
        else $error("irq falling edge missed");

    irq_rise_a: assert property (
        $rose(st_r.inS2[1]) && st_r.edgeA[2] && $past(st_r.edgeA[2])
        |=> extIrqReq[0])
        else $error("irq rising edge missed");

    reset_input_a: assert property (
        $fell(rst) |-> ioPinOeN == `OEN_RST && st_r.dir == `DIR_RST && st_r.fsel == 8'h0)
        else $error("io port not all inputs after reset");

    latch_drive_a: assert property (
        1'b1 |=> ((ioPinOut ^ $past(st_r.latch)) & ~$past(st_r.fsel)) == 8'h0)
        else $error("port-mode pin does not carry latch");

    input_hiz_a: assert property (
        1'b1 |=> (~ioPinOeN & ~$past(st_r.fsel) & $past(st_r.dir)) == 8'h0)
        else $error("input bit drives its pin");

    read_pin_a: assert property (
        arvalid && arready && araddr[`ADDR_W-1:2] == `IDX_IODATA
        |=> ((rdata[7:0] ^ $past(st_r.ioS2)) & $past(st_r.dir)) == 8'h0)
        else $error("direction-1 bit does not read pin");

    alt_drive_a: assert property (
        st_r.od == 2'h0
        |=> ((~ioPinOeN ^ $past(altOutEn)) & $past(st_r.fsel)) == 8'h0)
        else $error("alternate pin drive ignores peripheral");

    alt_internal_a: assert property (
        arvalid && arready && araddr[`ADDR_W-1:2] == `IDX_IODATA
        |=> ((rdata[7:0] ^ $past(altOut)) &
             $past(st_r.fsel) & ~$past(st_r.dir) & $past(altOutEn)) == 8'h0)
        else $error("alternate output does not read internal signal");

    io_pull_a: assert property (
        ioPullUp == ($past(st_r.dir) & {8{$past(st_r.pullOpt[`PULL_IO_BIT])}}))
        else $error("io port pull-up wrong");

    open_drain_a: assert property (
        $past(st_r.od[0]) && ioPinOut[`OD_PIN_CLK] |-> ioPinOeN[`OD_PIN_CLK])
        else $error("open-drain pin drives high");

    pull_bit7_a: assert property (
        st_r.pullOpt[7] == 1'b0)
        else $error("pull option bit 7 set");

    read_latch_a: assert property (
        arvalid && arready && araddr[`ADDR_W-1:2] == `IDX_IODATA
        |=> ((rdata[7:0] ^ $past(st_r.latch)) & ~$past(st_r.fsel) & ~$past(st_r.dir)) == 8'h0)
        else $error("output bit does not read latch");

    write_c: cover property (bvalid && bready && bresp == `RESP_OK);
    read_c: cover property (rvalid && rready && rresp == `RESP_OK);
    nmi_c: cover property (nmiReq);
    irq_c: cover property (extIrqReq != 6'h0);
    od_c: cover property (st_r.od[0] && ioPinOeN[`OD_PIN_CLK]);

endmodule

`default_nettype wire

// ---- pkg/edge_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface edge_if #(parameter int N = 1);
    logic [N-1:0] level;
    logic [N-1:0] riseEn;
    logic [N-1:0] fallEn;
    logic [N-1:0] req;
    modport det(input level, input riseEn, input fallEn, output req);
    modport src(output level, output riseEn, output fallEn, input req);
endinterface

`default_nettype wire

// ---- pkg/gpio_pair_params.svh ----
`ifndef GPIO_PAIR_PARAMS_SVH
`define GPIO_PAIR_PARAMS_SVH

// register indices; byte address is four times the index
`define ADDR_W 18
`define IDX_W 16
`define IDX_INPORT 16'hff40
`define IDX_IODATA 16'hff41
`define IDX_IODIR 16'hff42
`define IDX_IOFSEL 16'hff43
`define IDX_EDGE_A 16'hff44
`define IDX_EDGE_B 16'hff45
`define IDX_IOOD 16'hff46
`define IDX_PULL 16'hff4e

// field positions and masks
`define PULL_IN_BIT 2
`define PULL_IO_BIT 3
`define PULL_RW_MASK 8'h7f
`define NMI_EDGE_BIT 0
`define OD_PIN_CLK 2
`define OD_PIN_OUT 3
`define EDGE_PINS 7

// reset values and bus answers
`define DIR_RST 8'hff
`define OEN_RST 8'hff
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- pkg/gpio_pair_pkg.sv ----
`include "gpio_pair_params.svh"

package gpio_pair_pkg;

    typedef logic [7:0] byte_t;

    typedef struct packed {
        byte_t inS1;
        byte_t inS2;
        byte_t ioS1;
        byte_t ioS2;
        byte_t latch;
        byte_t dir;
        byte_t fsel;
        byte_t pullOpt;
        byte_t edgeA;
        byte_t edgeB;
        logic [1:0] od;
        byte_t ioOut;
        byte_t ioOeN;
        byte_t ioPull;
        byte_t inPull;
        logic awHeld;
        logic wHeld;
        logic wLow;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic [`ADDR_W-1:0] waddr;
        byte_t wdata;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        byte_t rdata;
    } port_state_s;

endpackage

// ---- verification/board_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module board_model (
    input wire logic core_clk,
    input wire gpio_pair_pkg::byte_t drvOut,
    input wire gpio_pair_pkg::byte_t drvOeN,
    input wire gpio_pair_pkg::byte_t pullUp,
    input wire gpio_pair_pkg::byte_t extVal,
    input wire gpio_pair_pkg::byte_t extEn,
    output gpio_pair_pkg::byte_t pad
);
    import gpio_pair_pkg::*;
    byte_t lastPad_r = 8'h00;
    // device drive wins over the board; a released open-drain pin falls to board or pull
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!drvOeN[i]) begin
                pad[i] = drvOut[i];
            end else if (extEn[i]) begin
                pad[i] = extVal[i];
            end else if (pullUp[i]) begin
                pad[i] = 1'b1;
            end else begin
                // floating pad toggles so a missing drive never looks stable
                pad[i] = ~lastPad_r[i];
            end
        end
    end
    always @(posedge core_clk) lastPad_r <= pad;
endmodule

`default_nettype wire

// ---- verification/input_and_io_port_pair_bench.sv ----
`include "gpio_pair_params.svh"
`timescale 1ns/10ps
`default_nettype none

module input_and_io_port_pair_bench;
    import gpio_pair_pkg::*;
    typedef struct packed {logic [15:0] idx; byte_t d; byte_t e; logic [1:0] r;} row_s;
    logic core_clk = 0;
    logic rst = 1;
    logic [17:0] awaddr = 0;
    logic [17:0] araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, wrLow = 1;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, nmiReq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [5:0] extIrqReq;
    byte_t inPin = 0, altOut = 0, altOutEn = 0, extVal = 0, extEn = 0;
    byte_t inPullUp, inRoute, ioPinIn, ioPinOut, ioPinOeN, ioPullUp, altIn, rd;
    int failures = 0, total_checks = 0, nmiCnt = 0, n0, i0, i1;
    int irqCnt [6] = '{default: 0};
    row_s rows [7] = '{'{`IDX_PULL, 8'hff, 8'h7f, 2'h0}, '{`IDX_IODIR, 8'h5a, 8'h5a, 2'h0},
        '{`IDX_IOFSEL, 8'h81, 8'h81, 2'h0}, '{`IDX_EDGE_A, 8'h3c, 8'h3c, 2'h0},
        '{`IDX_EDGE_B, 8'h15, 8'h15, 2'h0}, '{`IDX_INPORT, 8'hff, 8'h00, 2'h0},
        '{16'h0010, 8'h11, 8'h00, 2'h2}};

    always #5 core_clk = ~core_clk;

    input_and_io_port_pair u_input_and_io_port_pair (.core_clk(core_clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .inPin(inPin), .inPullUp(inPullUp),
        .inRoute(inRoute), .nmiReq(nmiReq), .extIrqReq(extIrqReq), .ioPinIn(ioPinIn),
        .ioPinOut(ioPinOut), .ioPinOeN(ioPinOeN), .ioPullUp(ioPullUp), .altOut(altOut),
        .altOutEn(altOutEn), .altIn(altIn));

    board_model u_board_model (.core_clk(core_clk), .drvOut(ioPinOut), .drvOeN(ioPinOeN),
        .pullUp(ioPullUp), .extVal(extVal), .extEn(extEn), .pad(ioPinIn));

    always @(posedge core_clk) begin
        nmiCnt <= nmiCnt + int'(nmiReq === 1'b1);
        for (int k = 0; k < 6; k++) irqCnt[k] <= irqCnt[k] + int'(extIrqReq[k] === 1'b1);
    end

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chkB(byte_t got, byte_t exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // bready rides along with the request; response is taken at the bvalid edge
    task automatic wr(logic [15:0] idx, byte_t d);
        int n;
        n = 0;
        @(posedge core_clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= {3'h0, wrLow};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (n < 200) begin
            @(posedge core_clk);
            n++;
            if (!awvalid && !wvalid && bvalid === 1'b1) break;
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
        end
        resp = bresp;
        bready <= 0;
        if (n >= 200) failures++;
    endtask

    task automatic rdReg(logic [15:0] idx);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        while (n < 200) begin
            @(posedge core_clk);
            n++;
            if (!arvalid && rvalid === 1'b1) break;
            if (arready === 1'b1) arvalid <= 0;
        end
        rd = rdata[7:0];
        resp = rresp;
        rready <= 0;
        if (n >= 200) failures++;
    endtask

    task automatic rdChk(logic [15:0] idx, byte_t exp);
        rdReg(idx);
        chkB(rd, exp);
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 0;
        tick(3);
        chkB(ioPinOeN, 8'hff);
        rdChk(`IDX_IODIR, 8'hff);
        rdChk(`IDX_PULL, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].d);
            chkB({6'h0, resp}, {6'h0, rows[i].r});
            if (rows[i].r == 2'h0) rdChk(rows[i].idx, rows[i].e);
        end
        rdReg(16'h0010);
        chkB({6'h0, resp}, 8'h02);
        // low byte strobe off: answered, register untouched
        wrLow = 1'b0;
        wr(`IDX_IODIR, 8'h00);
        wrLow = 1'b1;
        chkB({6'h0, resp}, 8'h00);
        rdChk(`IDX_IODIR, 8'h5a);
        wr(`IDX_IOFSEL, 8'h00);
        wr(`IDX_PULL, 8'h00);
        wr(`IDX_IODIR, 8'hff);
        wr(`IDX_IODATA, 8'h3c);
        tick(2);
        chkB(ioPinOeN, 8'hff);
        @(posedge core_clk);
        extVal <= 8'ha5;
        extEn <= 8'hf0;
        wr(`IDX_IODIR, 8'hf0);
        tick(6);
        chkB(ioPinOut & 8'h0f, 8'h0c);
        chkB(ioPinOeN, 8'hf0);
        rdChk(`IDX_IODATA, 8'hac);
        // bit set done as a byte rewrite: input bits take the pin level
        wr(`IDX_IODATA, rd | 8'h01);
        wr(`IDX_IODIR, 8'h00);
        @(posedge core_clk);
        extEn <= 8'h00;
        tick(2);
        chkB(ioPinOut, 8'had);
        wr(`IDX_IOOD, 8'h03);
        tick(2);
        chkB(ioPinOeN, 8'h0c);
        wr(`IDX_IODATA, 8'ha1);
        tick(2);
        chkB(ioPinOeN, 8'h00);
        wr(`IDX_IOOD, 8'h00);
        wr(`IDX_PULL, 8'h08);
        wr(`IDX_IODIR, 8'h3c);
        tick(2);
        chkB(ioPullUp, 8'h3c);
        chkB(inPullUp, 8'h00);
        wr(`IDX_PULL, 8'h04);
        tick(2);
        chkB(ioPullUp, 8'h00);
        chkB(inPullUp, 8'hfc);
        wr(`IDX_PULL, 8'h08);
        wr(`IDX_IOFSEL, 8'hff);
        wr(`IDX_IODIR, 8'h00);
        @(posedge core_clk);
        altOut <= 8'h96;
        altOutEn <= 8'h0f;
        tick(6);
        chkB(ioPinOut & 8'h0f, 8'h06);
        chkB(ioPinOeN, 8'hf0);
        chkB(ioPullUp, 8'h00);
        rdChk(`IDX_IODATA, 8'h06);
        wr(`IDX_IODIR, 8'hff);
        @(posedge core_clk);
        extVal <= 8'h5a;
        extEn <= 8'hf0;
        tick(6);
        chkB(ioPinOeN, 8'hf0);
        chkB(ioPullUp, 8'hff);
        chkB(altIn, 8'h56);
        rdChk(`IDX_IODATA, 8'h56);
        wr(`IDX_IOFSEL, 8'h00);
        @(posedge core_clk);
        inPin <= 8'hc3;
        tick(6);
        rdChk(`IDX_INPORT, 8'hc3);
        chkB(inRoute, 8'hc3);
        wr(`IDX_EDGE_A, 8'h05);
        wr(`IDX_EDGE_B, 8'h02);
        tick(8);
        n0 = nmiCnt;
        i0 = irqCnt[0];
        i1 = irqCnt[1];
        @(posedge core_clk);
        inPin <= 8'hc0;
        tick(8);
        @(posedge core_clk);
        inPin <= 8'hc7;
        tick(8);
        chkB(8'(nmiCnt - n0), 8'h01);
        chkB(8'(irqCnt[0] - i0), 8'h01);
        chkB(8'(irqCnt[1] - i1), 8'h00);
        @(posedge core_clk);
        inPin <= 8'hc3;
        tick(8);
        chkB(8'(irqCnt[1] - i1), 8'h01);
        chkB(8'(irqCnt[2] + irqCnt[3] + irqCnt[4] + irqCnt[5]), 8'h00);
        wr(`IDX_EDGE_A, 8'h00);
        @(posedge core_clk);
        inPin <= 8'hc2;
        tick(8);
        chkB(8'(nmiCnt - n0), 8'h02);
        @(posedge core_clk);
        rst <= 1;
        tick(2);
        chkB(ioPinOeN, 8'hff);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        summarize();
    end
endmodule

`default_nettype wire
